// ### ssr_pkg.sv
// ssr_pkg: constants and types of the synchronous serial receiver
// assumes a byte-wide register port with eight register slots
package ssr_pkg;

  // register slots on the register port
  localparam logic [2:0] ADDR_TXSTA = 3'h0; // transmit status/control
  localparam logic [2:0] ADDR_RCSTA = 3'h1; // receive status/control
  localparam logic [2:0] ADDR_RXDAT = 3'h2; // receive data
  localparam logic [2:0] ADDR_BAUD  = 3'h3; // baud control
  localparam logic [2:0] ADDR_DIVL  = 3'h4; // baud divisor low
  localparam logic [2:0] ADDR_DIVH  = 3'h5; // baud divisor high
  localparam logic [2:0] ADDR_IRQF  = 3'h6; // peripheral irq flags 1
  localparam logic [2:0] ADDR_IRQE  = 3'h7; // peripheral irq enable 1

  // bit positions
  localparam int TS_CLOCK_SOURCE_HOST_SELECT = 7; // clock source host select
  localparam int TS_SYNC = 4; // synchronous mode
  localparam int RS_PORT_ENABLE = 7; // port enable
  localparam int RS_RX9  = 6; // nine bit receive select
  localparam int RS_SINGLE_RECEIVE_ENABLE = 5; // single receive enable
  localparam int RS_CONTINUOUS_RECEIVE_ENABLE = 4; // continuous receive enable
  localparam int BC_CLOCK_POLARITY_BIT = 4; // clock polarity bit

  // masks of writable and read-only fields
  localparam logic [7:0] TS_WMASK   = 8'hfd; // all but transmit idle
  localparam logic [7:0] TS_TRMT_M  = 8'h02; // transmit idle, reads one
  localparam logic [7:0] RS_WMASK   = 8'hf8; // enables, nine bit, addr
  localparam logic [7:0] RS_OVERRUN_ERROR_FLAG_M  = 8'h02; // overrun error flag
  localparam logic [7:0] RS_RECEIVED_NINTH_BIT_M  = 8'h01; // received ninth bit
  localparam logic [7:0] BC_WMASK   = 8'h1b; // polarity, divisor mode
  localparam logic [7:0] BC_RCIDL_M = 8'h40; // receiver idle
  localparam logic [7:0] IRQ_RC_M   = 8'h20; // receive complete
  localparam logic [7:0] REG_RST    = 8'h00; // reset value of registers

  // character and queue sizes
  localparam logic [3:0]  BIT_FIRST  = 4'h0;
  localparam logic [3:0]  CHAR8_LAST = 4'h7;
  localparam logic [3:0]  CHAR9_LAST = 4'h8;
  localparam logic [1:0]  Q_EMPTY    = 2'h0;
  localparam logic [1:0]  Q_ONE      = 2'h1;
  localparam logic [1:0]  Q_FULL     = 2'h2;
  localparam logic [15:0] DIV_ZERO   = 16'h0000;

  // one received character
  typedef struct packed {
    logic       ninth; // ninth, most significant bit
    logic [7:0] data;  // low eight bits
  } ssr_char_s;

  // host shift clock phases
  typedef enum logic [1:0] {
    ST_IDLE,  // no clock, pin at idle level
    ST_REST,  // half period at idle level
    ST_DRIVE  // half period at active level
  } ssr_clk_e;

endpackage : ssr_pkg

// ### ssr_receiver.sv
// ssr_receiver: synchronous half-duplex receive path of a serial port
// assumes a same-clock register master and clock/data pins from outside

// Behaviour
// - host receive leaves data pin undriven
// - either receive enable starts reception
// - single receive: one character, then clear
// - continuous receive clocks until cleared
// - continuous cleared midway: stop, discard character
// - both set: single clears after first
// - sample data on trailing clock edge
// - full character sets flag, enters queue
// - data register shows oldest low byte
// - flag stays while queue holds characters
// - client mode: clock pin undriven, input clock
// - sender changes data on leading edge
// - third character sets overrun, keeps queue
// - overrun blocks reception, queue stays readable
// - single-mode overrun cleared by data read
// - continuous overrun cleared by enable clear
// - nine bit mode shifts nine bits
// - ninth bit field shows oldest ninth
// - sync, no host select: client mode
// - host drives one clock per bit
// - polarity bit sets idle level and edges
module ssr_receiver
  import ssr_pkg::*;
(
  input  wire logic       clk,            // system clock
  input  wire logic       rst_n,          // synchronous reset, low
  input  wire logic [2:0] reg_addr,       // register slot
  input  wire logic [7:0] reg_wdata,      // write data
  input  wire logic       reg_wr,         // write strobe
  input  wire logic       reg_rd,         // read strobe
  output logic      [7:0] reg_rdata,      // read data, next cycle
  input  wire logic       clock_pin_in,   // clock pin level
  output logic            clock_pin_out,  // clock pin drive value
  output logic            clock_pin_oe,   // clock pin drive enable
  input  wire logic       data_pin_in,    // data pin level
  output logic            data_pin_out,   // data pin drive value
  output logic            data_pin_oe,    // data pin drive enable
  output logic            receive_complete_flag // queue not empty
);

  // register storage
  logic [7:0] txsta_ff, rcsta_ff, baud_ff, divl_ff, divh_ff, irqe_ff;
  logic [7:0] nxt_rcsta;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       overrun_error_flag_ff, nxt_overrun_error_flag;
  logic       overrun_error_flag_cont_ff, nxt_overrun_error_flag_cont;
  // pin synchronisers
  logic       ck_s1_ff, ck_s2_ff, ck_s3_ff;
  logic       dt_s1_ff, dt_s2_ff;
  // host clock generator
  ssr_clk_e   state_ff, nxt_state;
  logic [15:0] div_cnt_ff, nxt_div_cnt;
  // shift path and queue
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [8:0] sr_ff, nxt_sr;
  ssr_char_s  q_ff [2];
  ssr_char_s  nxt_q [2];
  logic [1:0] cnt_ff, nxt_cnt;
  // pin outputs
  logic       ck_out_ff, ck_oe_ff, dt_out_ff, dt_oe_ff, receive_complete_flag_ff;

  // register index match
  function automatic logic hit(input logic [2:0] a,
                               input logic [2:0] slot);
    hit = (a == slot);
  endfunction : hit

  // configuration decode
  wire port_enable     = rcsta_ff[RS_PORT_ENABLE];
  wire single_receive_enable     = rcsta_ff[RS_SINGLE_RECEIVE_ENABLE];
  wire continuous_receive_enable     = rcsta_ff[RS_CONTINUOUS_RECEIVE_ENABLE];
  wire rx9      = rcsta_ff[RS_RX9];
  wire clock_source_host_select     = txsta_ff[TS_CLOCK_SOURCE_HOST_SELECT];
  wire sync_md  = txsta_ff[TS_SYNC];
  wire clock_polarity_bit     = baud_ff[BC_CLOCK_POLARITY_BIT];
  wire [15:0] divisor = {divh_ff, divl_ff};

  // receive enables and mode selection
  wire rx_en      = port_enable & sync_md & (single_receive_enable | continuous_receive_enable);
  wire rx_run     = rx_en & ~overrun_error_flag_ff;
  wire host_run   = rx_run & clock_source_host_select;
  wire client_run = rx_run & ~clock_source_host_select;

  // bus strobes by slot
  wire wr_txsta = reg_wr & hit(reg_addr, ADDR_TXSTA);
  wire wr_rcsta = reg_wr & hit(reg_addr, ADDR_RCSTA);
  wire wr_baud  = reg_wr & hit(reg_addr, ADDR_BAUD);
  wire wr_divl  = reg_wr & hit(reg_addr, ADDR_DIVL);
  wire wr_divh  = reg_wr & hit(reg_addr, ADDR_DIVH);
  wire wr_irqe  = reg_wr & hit(reg_addr, ADDR_IRQE);
  wire rd_data  = reg_rd & hit(reg_addr, ADDR_RXDAT);

  // host half-period tick from the divisor
  wire half_tick = host_run & (div_cnt_ff == divisor);
  assign nxt_div_cnt = (!host_run || half_tick) ? DIV_ZERO
                     : 16'(div_cnt_ff + 16'h0001);

  // client trailing edge: clock returns to its idle level
  wire client_trail = client_run & (ck_s3_ff != clock_polarity_bit)
                    & (ck_s2_ff == clock_polarity_bit);

  // sampling moments and character completion
  wire host_trail = host_run & half_tick & (state_ff == ST_DRIVE);
  wire sample     = host_trail | client_trail;
  wire [3:0] last_idx = rx9 ? CHAR9_LAST : CHAR8_LAST;
  wire char_done  = sample & (bit_cnt_ff == last_idx);
  wire pop        = rd_data & (cnt_ff != Q_EMPTY);
  wire ovf_evt    = char_done & (cnt_ff == Q_FULL) & ~pop;
  wire push       = char_done & ~ovf_evt;
  wire busy       = (state_ff != ST_IDLE) | (bit_cnt_ff != BIT_FIRST);

  // new character from the shift register
  ssr_char_s new_char;
  assign new_char.data  = nxt_sr[7:0];
  assign new_char.ninth = rx9 & nxt_sr[8];

  // host clock phase sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (host_run) nxt_state = ST_REST;
      end
      ST_REST: begin
        if (!host_run) nxt_state = ST_IDLE;
        else if (half_tick) nxt_state = ST_DRIVE;
      end
      ST_DRIVE: begin
        if (!host_run) nxt_state = ST_IDLE;
        else if (half_tick) nxt_state = ST_REST;
      end
    endcase
  end

  // bit counter, cleared when reception stops midway
  assign nxt_bit_cnt = (!rx_run || char_done) ? BIT_FIRST
                     : sample ? 4'(bit_cnt_ff + 4'h1)
                     : bit_cnt_ff;

  // shift register: each sampled bit lands at its own index
  always_comb begin
    nxt_sr = sr_ff;
    if (sample) nxt_sr[bit_cnt_ff] = dt_s2_ff;
  end

  // two-entry receive queue, oldest at slot zero
  always_comb begin
    nxt_q[0] = q_ff[0];
    nxt_q[1] = q_ff[1];
    nxt_cnt  = cnt_ff;
    if (pop) begin
      nxt_q[0] = q_ff[1];
      nxt_cnt  = 2'(cnt_ff - Q_ONE);
    end
    if (push) begin
      if (nxt_cnt == Q_EMPTY) nxt_q[0] = new_char;
      else nxt_q[1] = new_char;
      nxt_cnt = 2'(nxt_cnt + Q_ONE);
    end
    if (!port_enable) nxt_cnt = Q_EMPTY;
  end

  // overrun flag: set wins, cleared as the mode of its origin says
  wire overrun_error_flag_clr = ~port_enable | (overrun_error_flag_cont_ff ? ~continuous_receive_enable : rd_data);
  assign nxt_overrun_error_flag = ovf_evt | (overrun_error_flag_ff & ~overrun_error_flag_clr);
  assign nxt_overrun_error_flag_cont = ovf_evt ? continuous_receive_enable : overrun_error_flag_cont_ff;

  // receive control: a write beats the self-clear of single receive
  assign nxt_rcsta = wr_rcsta ? (reg_wdata & RS_WMASK)
                   : char_done ? (rcsta_ff & ~(8'h01 << RS_SINGLE_RECEIVE_ENABLE))
                   : rcsta_ff;

  // read views
  ssr_char_s head;
  assign head = q_ff[0];
  wire [7:0] rd_txsta = txsta_ff | TS_TRMT_M;
  wire [7:0] rd_rcsta = rcsta_ff | (overrun_error_flag_ff ? RS_OVERRUN_ERROR_FLAG_M : REG_RST)
                      | (head.ninth ? RS_RECEIVED_NINTH_BIT_M : REG_RST);
  wire [7:0] rd_baud  = baud_ff | (busy ? REG_RST : BC_RCIDL_M);
  wire [7:0] rd_irqf  = (cnt_ff != Q_EMPTY) ? IRQ_RC_M : REG_RST;
  wire [7:0] rd_mux =
      hit(reg_addr, ADDR_TXSTA) ? rd_txsta :
      hit(reg_addr, ADDR_RCSTA) ? rd_rcsta :
      hit(reg_addr, ADDR_RXDAT) ? head.data :
      hit(reg_addr, ADDR_BAUD)  ? rd_baud  :
      hit(reg_addr, ADDR_DIVL)  ? divl_ff  :
      hit(reg_addr, ADDR_DIVH)  ? divh_ff  :
      hit(reg_addr, ADDR_IRQF)  ? rd_irqf  : irqe_ff;
  assign nxt_rdata = reg_rd ? rd_mux : REG_RST;

  // software registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txsta_ff <= REG_RST;
      rcsta_ff <= REG_RST;
      baud_ff  <= REG_RST;
      divl_ff  <= REG_RST;
      divh_ff  <= REG_RST;
      irqe_ff  <= REG_RST;
      rdata_ff <= REG_RST;
    end else begin
      if (wr_txsta) txsta_ff <= reg_wdata & TS_WMASK;
      rcsta_ff <= nxt_rcsta;
      if (wr_baud) baud_ff <= reg_wdata & BC_WMASK;
      if (wr_divl) divl_ff <= reg_wdata;
      if (wr_divh) divh_ff <= reg_wdata;
      if (wr_irqe) irqe_ff <= reg_wdata;
      rdata_ff <= nxt_rdata;
    end
  end

  // two-flop synchronisers for the pins, plus a delayed clock copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ck_s1_ff <= 1'b0;
      ck_s2_ff <= 1'b0;
      ck_s3_ff <= 1'b0;
      dt_s1_ff <= 1'b0;
      dt_s2_ff <= 1'b0;
    end else begin
      ck_s1_ff <= clock_pin_in;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
      dt_s1_ff <= data_pin_in;
      dt_s2_ff <= dt_s1_ff;
    end
  end

  // receive datapath and status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff     <= ST_IDLE;
      div_cnt_ff   <= DIV_ZERO;
      bit_cnt_ff   <= BIT_FIRST;
      sr_ff        <= 9'h000;
      q_ff[0]      <= 9'h000;
      q_ff[1]      <= 9'h000;
      cnt_ff       <= Q_EMPTY;
      overrun_error_flag_ff      <= 1'b0;
      overrun_error_flag_cont_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      div_cnt_ff   <= nxt_div_cnt;
      bit_cnt_ff   <= nxt_bit_cnt;
      sr_ff        <= nxt_sr;
      q_ff[0]      <= nxt_q[0];
      q_ff[1]      <= nxt_q[1];
      cnt_ff       <= nxt_cnt;
      overrun_error_flag_ff      <= nxt_overrun_error_flag;
      overrun_error_flag_cont_ff <= nxt_overrun_error_flag_cont;
    end
  end

  // pin drivers; the data pin is never driven by the receiver
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ck_out_ff <= 1'b0;
      ck_oe_ff  <= 1'b0;
      dt_out_ff <= 1'b0;
      dt_oe_ff  <= 1'b0;
      receive_complete_flag_ff   <= 1'b0;
    end else begin
      ck_out_ff <= clock_polarity_bit ^ (nxt_state == ST_DRIVE);
      ck_oe_ff  <= port_enable & sync_md & clock_source_host_select;
      dt_out_ff <= 1'b0;
      dt_oe_ff  <= 1'b0;
      receive_complete_flag_ff   <= (nxt_cnt != Q_EMPTY);
    end
  end

  assign reg_rdata             = rdata_ff;
  assign clock_pin_out         = ck_out_ff;
  assign clock_pin_oe          = ck_oe_ff;
  assign data_pin_out          = dt_out_ff;
  assign data_pin_oe           = dt_oe_ff;
  assign receive_complete_flag = receive_complete_flag_ff;

  // checks on the receive path
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_data_undriven;
    !data_pin_oe;
  endproperty
  a_data_undriven: assert property (p_data_undriven)
    else $error("data pin driven by receiver");

  property p_start;
    (state_ff == ST_IDLE) && host_run |=> state_ff == ST_REST;
  endproperty
  a_start: assert property (p_start)
    else $error("host clock did not start");

  property p_single_clear;
    char_done && !wr_rcsta |=> !rcsta_ff[RS_SINGLE_RECEIVE_ENABLE];
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single receive not cleared");

  property p_stop;
    !host_run |=> state_ff == ST_IDLE ##0 clock_pin_out == $past(clock_polarity_bit);
  endproperty
  a_stop: assert property (p_stop)
    else $error("host clock did not stop");

  property p_discard;
    !rx_run |=> bit_cnt_ff == BIT_FIRST;
  endproperty
  a_discard: assert property (p_discard)
    else $error("partial character kept");

  property p_push;
    char_done && (cnt_ff == Q_EMPTY) |=> cnt_ff == Q_ONE && receive_complete_flag_ff;
  endproperty
  a_push: assert property (p_push)
    else $error("character not queued");

  property p_flag;
    receive_complete_flag == (cnt_ff != Q_EMPTY);
  endproperty
  a_flag: assert property (p_flag)
    else $error("receive flag mismatch");

  property p_overrun;
    ovf_evt |=> overrun_error_flag_ff && cnt_ff == Q_FULL && $stable(q_ff[1]);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not handled");

  property p_blocked;
    overrun_error_flag_ff |-> !sample && !push;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("character taken during overrun");

  property p_clr_read;
    overrun_error_flag_ff && !overrun_error_flag_cont_ff && rd_data |=> !overrun_error_flag_ff;
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("overrun not cleared by read");

  property p_clr_cont;
    overrun_error_flag_ff && overrun_error_flag_cont_ff && !continuous_receive_enable |=> !overrun_error_flag_ff;
  endproperty
  a_clr_cont: assert property (p_clr_cont)
    else $error("overrun not cleared by enable");

  property p_read_data;
    rd_data |=> reg_rdata == $past(head.data);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("wrong receive data");

  property p_pop;
    pop && !push |=> cnt_ff == 2'($past(cnt_ff) - Q_ONE);
  endproperty
  a_pop: assert property (p_pop)
    else $error("read did not pop queue");

  property p_client_oe;
    !clock_source_host_select |=> !clock_pin_oe;
  endproperty
  a_client_oe: assert property (p_client_oe)
    else $error("clock driven in client mode");

endmodule : ssr_receiver

// ### ssr_far_end.sv
// ssr_far_end: far serial party facing the receiver, behavioural
// assumes the bench resolves both pins and queues characters here
module ssr_far_end (
  input  wire logic clock_pin, // resolved clock pin level
  input  wire logic polarity,  // idle level of the clock
  input  wire logic client,    // receiver is client, we are host
  output logic      clk_drv,   // clock we drive as host
  output logic      clk_oe,    // clock drive enable
  output logic      data_drv   // data we drive
);
  timeunit 1ns;
  timeprecision 1ns;

  int unsigned chars[$];   // characters still to send
  int          nbits = 8;  // bits per character
  int          idx   = 0;  // next bit of current character
  int          edges = 0;  // trailing edges seen
  logic [8:0]  cur   = '0; // character being sent

  assign clk_oe = client;

  initial begin
    clk_drv  = 1'b0;
    data_drv = 1'b0;
  end

  // receiver is host: new bit on leading edge, lsb first
  always @(clock_pin) begin
    if (!client && clock_pin != polarity) begin
      if (idx == 0)
        cur = (chars.size() > 0) ? 9'(chars.pop_front()) : 9'($urandom);
      data_drv = cur[idx];
      idx = (idx + 1) % nbits;
    end else if (!client) begin
      edges++;
      if (idx == 0)
        data_drv <= #350 ~data_drv; // line let go after the hold time
    end
  end

  // we are host: 800 ns clock, standing still outside the frame
  task automatic send_client(input logic [8:0] c, input int n);
    clk_drv = polarity;
    #37;
    for (int i = 0; i < n; i++) begin
      clk_drv  = ~polarity;
      data_drv = c[i];
      #400 clk_drv = polarity;
      #400;
    end
    data_drv = ~data_drv; // line let go after the frame
  endtask : send_client

endmodule : ssr_far_end

// ### ssr_receiver_bench.sv
// ssr_receiver_bench: self-checking bench of the synchronous receiver
// assumes ssr_pkg, ssr_receiver and ssr_far_end compiled before it
module ssr_receiver_bench
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk, rst_n, reg_wr, reg_rd, pol, client;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic       ck_out, ck_oe, dt_out, dt_oe, flag, far_ck, far_ck_oe, far_dt;
  int         fails, checks, cycles, c;
  int         exp_q[$]; // model of the receive queue
  // pin levels: clock line keeps its idle level when nobody drives
  wire logic  ck_pin = ck_oe ? ck_out : (far_ck_oe ? far_ck : pol);
  wire logic  dt_pin = dt_oe ? dt_out : far_dt; // pins are digital

  ssr_receiver dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clock_pin_in(ck_pin), .clock_pin_out(ck_out), .clock_pin_oe(ck_oe),
    .data_pin_in(dt_pin), .data_pin_out(dt_out), .data_pin_oe(dt_oe),
    .receive_complete_flag(flag));

  ssr_far_end far (
    .clock_pin(ck_pin), .polarity(pol), .client(client),
    .clk_drv(far_ck), .clk_oe(far_ck_oe), .data_drv(far_dt));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // poll receive status until the masked bits match
  task automatic poll(input logic [7:0] m, input logic [7:0] want);
    int n;
    n = 0;
    do begin
      rd(ADDR_RCSTA, v);
      n++;
    end while ((v & m) !== want && n < 300);
    check(v & m, want);
  endtask : poll

  // one single-receive character from the far side
  task automatic single_rx(input int ch, input logic [7:0] cfg);
    exp_q.push_back(cfg[RS_RX9] ? ch : ch & 'hff);
    far.chars.push_back(ch);
    wr(ADDR_RCSTA, cfg | 8'h20);
    poll(8'h20, 8'h00);
  endtask : single_rx

  // ninth bit first, then low byte, against the model queue
  task automatic read_char();
    int e;
    e = exp_q.pop_front();
    check(flag, 1'b1);
    rd(ADDR_RCSTA, v);
    check(v[0], e[8]);
    rd(ADDR_RXDAT, v);
    check(v, e[7:0]);
    check(flag, exp_q.size() > 0);
  endtask : read_char

  task automatic conclude();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    void'($urandom(91804));
    {rst_n, reg_wr, reg_rd, pol, client} = '0;
    {reg_addr, reg_wdata, fails, checks, cycles} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, read-only flag register
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      check(v, a == 0 ? TS_TRMT_M : (a == 3 ? BC_RCIDL_M : REG_RST));
    end
    wr(ADDR_IRQF, 8'hff);
    rd(ADDR_IRQF, v);
    check(v, 8'h00);
    wr(ADDR_TXSTA, 8'h90);
    wr(ADDR_DIVL, 8'h03);
    // single receive under both clock polarities
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      wr(ADDR_BAUD, p ? 8'h10 : 8'h00);
      wr(ADDR_RCSTA, 8'h80);
      repeat (3) @(posedge clk);
      check({ck_oe, ck_out, dt_oe, dt_out}, {1'b1, p[0], 2'b00});
      far.edges = 0;
      single_rx($urandom & 'h1ff, 8'h80);
      repeat (20) @(posedge clk);
      check(far.edges, 8);
      check(ck_out, p[0]);
      read_char();
    end
    // nine bits, both enables, third character overruns
    far.nbits = 9;
    far.edges = 0;
    wr(ADDR_RCSTA, 8'hc0);
    for (int i = 0; i < 3; i++) begin
      c = $urandom & 'h1ff;
      far.chars.push_back(c);
      if (i < 2)
        exp_q.push_back(c);
    end
    wr(ADDR_RCSTA, 8'hf0);
    poll(8'h02, 8'h02);
    repeat (100) @(posedge clk);
    check(far.edges, 27);
    read_char();
    read_char();
    rd(ADDR_RCSTA, v);
    check(v & 8'hfe, 8'hd2);
    wr(ADDR_RCSTA, 8'hc0);
    rd(ADDR_RCSTA, v);
    check(v & 8'hfe, 8'hc0);
    // single-receive overrun cleared by a data read
    far.nbits = 8;
    wr(ADDR_RCSTA, 8'h80);
    for (int i = 0; i < 3; i++)
      single_rx($urandom & 'hff, 8'h80);
    void'(exp_q.pop_back());
    check(v & 8'h02, 8'h02);
    read_char();
    rd(ADDR_RCSTA, v);
    check(v & 8'h02, 8'h00);
    read_char();
    // continuous cleared mid character
    far.chars.push_back($urandom);
    far.edges = 0;
    wr(ADDR_RCSTA, 8'h90);
    while (far.edges < 3) @(posedge clk);
    wr(ADDR_RCSTA, 8'h80);
    repeat (2) @(posedge clk);
    c = far.edges;
    repeat (60) @(posedge clk);
    check({ck_out, flag}, {pol, 1'b0});
    check(far.edges, c);
    far.idx = 0;
    far.chars.delete();
    single_rx($urandom & 'hff, 8'h80);
    read_char();
    // client mode, clock from the far side
    far.clk_drv = pol;
    client <= 1'b1;
    wr(ADDR_TXSTA, 8'h10);
    wr(ADDR_RCSTA, 8'h90);
    repeat (3) @(posedge clk);
    check(ck_oe, 1'b0);
    for (int i = 0; i < 2; i++) begin
      c = $urandom & 'hff;
      exp_q.push_back(c);
      far.send_client(9'(c), 8);
      repeat (10) @(posedge clk);
      read_char();
    end
    conclude();
  end

endmodule : ssr_receiver_bench
